/* design/srg_ctrl_pkg.sv */
package srg_ctrl_pkg;

  // Register map: one 16-bit control word plus two companion words
  localparam logic [3:0] ADDR_CONTROL_UPPER = 4'h0;
  localparam logic [3:0] ADDR_RATE_CONFIG   = 4'h1;
  localparam logic [3:0] ADDR_WORD_STATUS   = 4'h2;

  // Field positions of the control word
  localparam int FREE_RUN_BIT   = 9;
  localparam int SOFT_STOP_BIT  = 8;
  localparam int FSYNC_RST_BIT  = 7;
  localparam int RATE_RST_BIT   = 6;

  // Values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0]  CLK_DIV_RESET = 8'h01;
  localparam logic [7:0]  FRAME_PERIOD_RESET = 8'h0F;
  localparam logic [4:0]  WORD_BITS_RESET = 5'h0F;

  // Generated clock divide while in device-reset state
  localparam int RESET_CLK_DIVIDE = 2;

  // Halt behaviour selected by free-run and soft-stop
  typedef enum logic [1:0] {
    HALT_NONE,
    HALT_NOW,
    HALT_AFTER_WORD
  } halt_mode_t;

  // Control fields as held
  typedef struct packed {
    logic free_run;
    logic soft_stop;
    logic fsync_gen_reset_n;
    logic rate_gen_reset_n;
    logic by_device_reset;
  } control_t;

  // Rate configuration
  typedef struct packed {
    logic [7:0] clk_div;
    logic [7:0] frame_period;
  } rate_cfg_t;

  // Halt requests per direction
  typedef struct packed {
    logic tx_halt;
    logic rx_halt;
  } halt_t;

endpackage

/* design/serial_port_srg_reset_emu_ctrl.sv */
`timescale 1ns/1ps
// Function
// - Bits 15 to 10 read zero and ignore writes.
// - Free-run bit keeps transmit and receive clocks running at breakpoint.
// - With free-run zero, soft-stop selects breakpoint clock response.
// - A halted clock also halts its transmission or reception.
// - Bit 7 is active-low frame-sync logic reset, reads back its state.
// - Frame-sync logic in reset produces no generated frame sync.
// - Frame sync produced only while both reset bits are one.
// - Bit 6 is active-low sample rate generator reset, reads back state.
// - After device reset generated clock is CPU clock over two, sync low.
// - After software reset write, generated clock and sync held low.
// - With generator enabled, clock follows configured divider.
// - Control bits read zero after reset and are readable and writable.
module serial_port_srg_reset_emu_ctrl #(
  parameter int WORD_BITS = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Debugger halt request, from a pin
  input  wire logic        breakpoint,
  // Word boundary pulses from the shifters, same clock
  input  wire logic        tx_word_done,
  input  wire logic        rx_word_done,
  // Generated outputs
  output logic             generated_clock,
  output logic             generated_fsync,
  output logic             tx_clock_enable,
  output logic             rx_clock_enable
);

  // Whole state of the block
  typedef struct packed {
    srg_ctrl_pkg::control_t  ctl;
    srg_ctrl_pkg::rate_cfg_t cfg;
    logic [15:0]             rdata;
    logic [1:0]              bp_sync;
    logic [7:0]              div_cnt;
    logic [7:0]              frame_cnt;
    logic                    clk_out;
    logic                    fsync_out;
    srg_ctrl_pkg::halt_t     halt;
  } state_t;

  state_t st;
  state_t next_st;

  logic                    bp_level;
  srg_ctrl_pkg::halt_mode_t mode;
  logic                    clk_rise;

  assign bp_level = st.bp_sync[1];

  // Halt mode selection
  always_comb begin
    if (st.ctl.free_run) begin
      mode = srg_ctrl_pkg::HALT_NONE;
    end else if (st.ctl.soft_stop) begin
      mode = srg_ctrl_pkg::HALT_AFTER_WORD;
    end else begin
      mode = srg_ctrl_pkg::HALT_NOW;
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.bp_sync = {st.bp_sync[0], breakpoint};
    clk_rise = 1'b0;

    // Register writes
    if (wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER) begin
      next_st.ctl.free_run          = wdata[srg_ctrl_pkg::FREE_RUN_BIT];
      next_st.ctl.soft_stop         = wdata[srg_ctrl_pkg::SOFT_STOP_BIT];
      next_st.ctl.fsync_gen_reset_n = wdata[srg_ctrl_pkg::FSYNC_RST_BIT];
      next_st.ctl.rate_gen_reset_n  = wdata[srg_ctrl_pkg::RATE_RST_BIT];
      next_st.ctl.by_device_reset   = 1'b0;
    end
    if (wr && addr == srg_ctrl_pkg::ADDR_RATE_CONFIG) begin
      next_st.cfg = wdata;
    end

    // Register reads, answered next cycle
    next_st.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        srg_ctrl_pkg::ADDR_CONTROL_UPPER: begin
          next_st.rdata[srg_ctrl_pkg::FREE_RUN_BIT]  = st.ctl.free_run;
          next_st.rdata[srg_ctrl_pkg::SOFT_STOP_BIT] = st.ctl.soft_stop;
          next_st.rdata[srg_ctrl_pkg::FSYNC_RST_BIT] =
            st.ctl.fsync_gen_reset_n;
          next_st.rdata[srg_ctrl_pkg::RATE_RST_BIT]  =
            st.ctl.rate_gen_reset_n;
        end
        srg_ctrl_pkg::ADDR_RATE_CONFIG: begin
          next_st.rdata = st.cfg;
        end
        srg_ctrl_pkg::ADDR_WORD_STATUS: begin
          next_st.rdata = {12'h000, st.clk_out, st.fsync_out,
                           st.halt.tx_halt, st.halt.rx_halt};
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end

    // Generated clock
    if (!st.ctl.rate_gen_reset_n) begin
      next_st.div_cnt = 8'h00;
      next_st.frame_cnt = 8'h00;
      if (st.ctl.by_device_reset) begin
        // toggle each cycle: CPU clock over two
        next_st.clk_out = ~st.clk_out;
      end else begin
        next_st.clk_out = 1'b0;
      end
    end else begin
      // configured divider, half period clk_div+1 cycles
      if (st.div_cnt >= st.cfg.clk_div) begin
        next_st.div_cnt = 8'h00;
        next_st.clk_out = ~st.clk_out;
        clk_rise = ~st.clk_out;
      end else begin
        next_st.div_cnt = st.div_cnt + 8'h01;
      end
    end

    // Frame sync: one generated-clock period per frame slot
    // needs both reset bits high
    if (st.ctl.rate_gen_reset_n && st.ctl.fsync_gen_reset_n) begin
      if (clk_rise) begin
        if (st.frame_cnt >= st.cfg.frame_period) begin
          next_st.frame_cnt = 8'h00;
          next_st.fsync_out = 1'b1;
        end else begin
          next_st.frame_cnt = st.frame_cnt + 8'h01;
          next_st.fsync_out = 1'b0;
        end
      end else begin
        // Pulse lasts a single CPU clock cycle
        next_st.fsync_out = 1'b0;
      end
    end else begin
      next_st.fsync_out = 1'b0;
      if (st.ctl.rate_gen_reset_n) begin
        next_st.frame_cnt = 8'h00;
      end
    end

    // Breakpoint halt per direction
    // halt now or at word end
    if (!bp_level || mode == srg_ctrl_pkg::HALT_NONE) begin
      next_st.halt = '0;
    end else if (mode == srg_ctrl_pkg::HALT_NOW) begin
      next_st.halt = 2'b11;
    end else begin
      if (tx_word_done) begin
        next_st.halt.tx_halt = 1'b1;
      end
      if (rx_word_done) begin
        next_st.halt.rx_halt = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctl.by_device_reset <= 1'b1;
      st.cfg <= {srg_ctrl_pkg::CLK_DIV_RESET,
                 srg_ctrl_pkg::FRAME_PERIOD_RESET};
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign rdata           = st.rdata;
  assign generated_clock = st.clk_out;
  assign generated_fsync = st.fsync_out;
  assign tx_clock_enable = ~st.halt.tx_halt;
  assign rx_clock_enable = ~st.halt.rx_halt;

  // Reserved bits read zero check
  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd) |-> rdata[15:10] == 6'h00)
    else $error("reserved bits not zero");

  a_fsync_needs_both: assert property (@(posedge clk)
    disable iff (!rst_n)
    generated_fsync |-> $past(st.ctl.rate_gen_reset_n)
                        && $past(st.ctl.fsync_gen_reset_n))
    else $error("frame sync while in reset");

  a_fsync_reset_off: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.fsync_gen_reset_n ##1 !st.ctl.fsync_gen_reset_n
      |-> !generated_fsync)
    else $error("frame sync from reset logic");

  a_reset_half_rate: assert property (@(posedge clk)
    disable iff (!rst_n)
    st.ctl.by_device_reset && !st.ctl.rate_gen_reset_n
      |=> generated_clock != $past(generated_clock))
    else $error("clock not CPU over two");

  a_sw_reset_low: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.rate_gen_reset_n && !st.ctl.by_device_reset
      |=> !generated_clock && !generated_fsync)
    else $error("outputs not low in software reset");

  a_free_runs: assert property (@(posedge clk)
    disable iff (!rst_n)
    st.ctl.free_run |=> tx_clock_enable && rx_clock_enable)
    else $error("clock halted in free run");

  a_hard_stop: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.free_run && !st.ctl.soft_stop && bp_level
      |=> !tx_clock_enable && !rx_clock_enable)
    else $error("immediate stop missed");

  a_soft_wait: assert property (@(posedge clk)
    disable iff (!rst_n)
    $rose(st.halt.tx_halt) && $past(mode) == srg_ctrl_pkg::HALT_AFTER_WORD
      |-> $past(tx_word_done))
    else $error("soft stop before word end");

  a_ctrl_readback: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER ##1 rd
      && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> rdata[9:6] == $past(wdata[9:6], 2))
    else $error("control readback mismatch");

  a_divider_run: assert property (@(posedge clk)
    disable iff (!rst_n)
    st.ctl.rate_gen_reset_n && st.cfg.clk_div == 8'h00
      && $past(st.ctl.rate_gen_reset_n)
      |=> generated_clock != $past(generated_clock))
    else $error("divider not running");

  a_halt_release: assert property (@(posedge clk)
    disable iff (!rst_n)
    !bp_level |=> tx_clock_enable && rx_clock_enable)
    else $error("clock still halted after breakpoint");

  a_rate_bit_write: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> st.ctl.rate_gen_reset_n
          == $past(wdata[srg_ctrl_pkg::RATE_RST_BIT]))
    else $error("generator reset bit not written");

  a_fsync_bit_write: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> st.ctl.fsync_gen_reset_n
          == $past(wdata[srg_ctrl_pkg::FSYNC_RST_BIT]))
    else $error("frame-sync reset bit not written");

  a_halt_bits_write: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> st.ctl.free_run == $past(wdata[srg_ctrl_pkg::FREE_RUN_BIT])
          && st.ctl.soft_stop == $past(wdata[srg_ctrl_pkg::SOFT_STOP_BIT]))
    else $error("halt control bits not written");

  a_low_bits_zero: assert property (@(posedge clk)
    disable iff (!rst_n)
    rd && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> rdata[5:0] == 6'h00)
    else $error("unused control bits not zero");

  a_rdata_idle: assert property (@(posedge clk)
    disable iff (!rst_n)
    !$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");

  a_rate_reset_fsync: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.rate_gen_reset_n |=> !generated_fsync)
    else $error("frame sync during generator reset");

  a_soft_rx_wait: assert property (@(posedge clk)
    disable iff (!rst_n)
    $rose(st.halt.rx_halt) && $past(mode) == srg_ctrl_pkg::HALT_AFTER_WORD
      |-> $past(rx_word_done))
    else $error("receive soft stop before word end");

  a_write_ends_flavour: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr && addr == srg_ctrl_pkg::ADDR_CONTROL_UPPER
      |=> !st.ctl.by_device_reset)
    else $error("device reset flavour kept after write");

  a_frame_cnt_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.fsync_gen_reset_n && st.ctl.rate_gen_reset_n
      |=> st.frame_cnt == 8'h00)
    else $error("frame counter runs in reset");

  a_div_cnt_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    !st.ctl.rate_gen_reset_n |=> st.div_cnt == 8'h00)
    else $error("divider runs in generator reset");

  // Main scenarios
  c_device_half: cover property (@(posedge clk) disable iff (!rst_n)
    st.ctl.by_device_reset && $rose(generated_clock));
  c_fsync_pulse: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(generated_fsync));
  c_soft_halt: cover property (@(posedge clk) disable iff (!rst_n)
    mode == srg_ctrl_pkg::HALT_AFTER_WORD && $rose(st.halt.rx_halt));
  c_hard_halt: cover property (@(posedge clk) disable iff (!rst_n)
    mode == srg_ctrl_pkg::HALT_NOW && $fell(tx_clock_enable));
  c_sw_reset: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(st.ctl.rate_gen_reset_n));

endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // Clock, reset and register port
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  // Halt request and word boundaries
  logic        breakpoint;
  logic        tx_word_done;
  logic        rx_word_done;
  // Generated outputs
  logic        generated_clock;
  logic        generated_fsync;
  logic        tx_clock_enable;
  logic        rx_clock_enable;
  int          fails;
  int          n_compared;
  int          n;

  serial_port_srg_reset_emu_ctrl #(.WORD_BITS(16)) i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .breakpoint(breakpoint),
    .tx_word_done(tx_word_done), .rx_word_done(rx_word_done),
    .generated_clock(generated_clock), .generated_fsync(generated_fsync),
    .tx_clock_enable(tx_clock_enable), .rx_clock_enable(rx_clock_enable)
  );

  // Free-running bench clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic read_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, exp);
  endtask

  // Counts level changes of one output over a run of cycles
  task automatic count_changes(input int cycles, input bit fs, output int c);
    logic prev;
    c = 0;
    @(posedge clk);
    #1;
    prev = fs ? generated_fsync : generated_clock;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if ((fs ? generated_fsync : generated_clock) !== prev) c++;
      prev = fs ? generated_fsync : generated_clock;
    end
  endtask

  task automatic t_after_reset();
    read_check(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h0000);
    read_check(4'hF, 16'h0000);
    read_check(srg_ctrl_pkg::ADDR_RATE_CONFIG, 16'h010F);
    count_changes(8, 1'b0, n);
    check("reset clock toggles", 16'(n), 16'h0008);
    check("reset fsync", {15'h0000, generated_fsync}, 16'h0000);
  endtask

  task automatic t_generator_modes();
    int k;
    write_reg(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'hFFFF);
    read_check(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h03C0);
    count_changes(16, 1'b0, n);
    check("divided clock toggles", 16'(n), 16'h0008);
    for (k = 0; k < 200 && generated_fsync !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      check("fsync timeout", 16'h0001, 16'h0000);
      test_done();
    end
    @(posedge clk);
    #1;
    check("fsync width", {15'h0000, generated_fsync}, 16'h0000);
    write_reg(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h0040);
    count_changes(100, 1'b1, n);
    check("fsync in frame reset", 16'(n), 16'h0000);
    write_reg(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h0080);
    read_check(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h0080);
    count_changes(20, 1'b0, n);
    check("clock held", {15'(n), generated_clock}, 16'h0000);
    check("fsync held", {15'h0000, generated_fsync}, 16'h0000);
  endtask

  task automatic t_halt(input logic [15:0] ctl, input logic [1:0] exp);
    write_reg(srg_ctrl_pkg::ADDR_CONTROL_UPPER, ctl);
    breakpoint <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check("enables", {tx_clock_enable, rx_clock_enable}, exp);
  endtask

  task automatic t_soft_stop();
    t_halt(16'h0100, 2'b11);
    tx_word_done <= 1'b1;
    @(posedge clk);
    tx_word_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("tx after word", {tx_clock_enable, rx_clock_enable}, 2'b01);
    rx_word_done <= 1'b1;
    @(posedge clk);
    rx_word_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rx after word", {tx_clock_enable, rx_clock_enable}, 2'b00);
    breakpoint <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("resume", {tx_clock_enable, rx_clock_enable}, 2'b11);
  endtask

  task automatic t_rate_config();
    write_reg(srg_ctrl_pkg::ADDR_CONTROL_UPPER, 16'h0040);
    write_reg(srg_ctrl_pkg::ADDR_RATE_CONFIG, 16'h000F);
    read_check(srg_ctrl_pkg::ADDR_RATE_CONFIG, 16'h000F);
    count_changes(8, 1'b0, n);
    check("undivided clock toggles", 16'(n), 16'h0008);
  endtask

  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    breakpoint = 1'b0;
    tx_word_done = 1'b0;
    rx_word_done = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_after_reset();
    t_generator_modes();
    t_halt(16'h0200, 2'b11);
    t_halt(16'h0000, 2'b00);
    breakpoint <= 1'b0;
    t_soft_stop();
    t_rate_config();
    test_done();
  end
endmodule
